/* File: hw/spcf_pkg.sv */
package spcf_pkg;
    localparam int SAMPLE_W = 12;
    localparam int WORD_W = 24;
    localparam int ADDR_W = 6;
    localparam int ACC_FRAC = 8;
    localparam int ACC_W = SAMPLE_W + ACC_FRAC;
    // Register offsets
    localparam logic [5:0] FILTER_TRIM_OFS = 6'h08;
    localparam logic [5:0] CURVE_TAG_OFS = 6'h1B;
    localparam logic [5:0] LIMITS_OFS = 6'h1C;
    localparam logic [23:0] WORD_RESET = 24'h000000;
    // Field positions
    localparam int BW_LSB = 0;
    localparam int CURVE_VALID_BIT = 23;
    localparam int POST_FLIP_BIT = 22;
    localparam int PRE_FLIP_BIT = 21;
    localparam int TAG_LSB = 12;
    localparam int TAG_MSB = 20;
    localparam int CLAMP_HI_LSB = 18;
    localparam int CLAMP_LO_LSB = 12;
    localparam int CLAMP_W = 6;
    // Bandwidth codes
    typedef enum logic [1:0] {
        SPCF_BW_1500 = 2'b00,
        SPCF_BW_FACTORY = 2'b01,
        SPCF_BW_375 = 2'b10,
        SPCF_BW_3000 = 2'b11
    } spcf_bw_e;
    localparam int BW_1500_HZ = 1500;
    localparam int BW_375_HZ = 375;
    localparam int BW_3000_HZ = 3000;
    // Smoothing shifts; each halving of bandwidth adds one
    localparam int SHIFT_3000 = 3;
    localparam int SHIFT_1500 = SHIFT_3000 + 1;
    localparam int SHIFT_375 = SHIFT_1500 + 2;
    // Clamp arithmetic: half scale split into 64 steps
    localparam int CLAMP_STEPS = 64;
    localparam logic [11:0] FULL_SCALE = 12'hFFF;
    localparam logic [11:0] MID_OFFSET = 12'h800;
    localparam int CLAMP_STEP_LSB = 2048 / CLAMP_STEPS;
    localparam logic signed [11:0] SMAX = 12'sh7FF;
    localparam logic signed [11:0] SMIN = 12'sh800;
endpackage : spcf_pkg

/* File: hw/spcf_path_if.sv */
`timescale 1ns/1ps
interface spcf_path_if;
    logic signed [11:0] raw;
    logic raw_valid;
    logic [1:0] bw_sel;
    logic signed [11:0] filt;
    logic filt_valid;
    modport filt_side (input raw, input raw_valid, input bw_sel,
        output filt, output filt_valid);
    modport top_side (output raw, output raw_valid, output bw_sel,
        input filt, input filt_valid);
endinterface : spcf_path_if

/* File: hw/spcf_filter.sv */
`timescale 1ns/1ps
module spcf_filter (
    input wire logic mclk_in,
    input wire logic rst_in,
    spcf_path_if.filt_side path
);
    logic signed [spcf_pkg::ACC_W-1:0] acc_r;
    logic signed [spcf_pkg::ACC_W-1:0] acc_nxt;
    logic signed [spcf_pkg::ACC_W-1:0] x_ext;
    logic signed [spcf_pkg::ACC_W-1:0] diff;
    int shift;

    always_comb
    begin
        case (spcf_pkg::spcf_bw_e'(path.bw_sel))
            spcf_pkg::SPCF_BW_375: shift = spcf_pkg::SHIFT_375;
            spcf_pkg::SPCF_BW_3000: shift = spcf_pkg::SHIFT_3000;
            default: shift = spcf_pkg::SHIFT_1500;
        endcase
        x_ext = {path.raw, {spcf_pkg::ACC_FRAC{1'b0}}};
        diff = x_ext - acc_r;
        acc_nxt = acc_r + (diff >>> shift);
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc_r <= '0;
            path.filt_valid <= 1'b0;
        end
        else
        begin
            path.filt_valid <= path.raw_valid;
            if (path.raw_valid)
                acc_r <= acc_nxt;
        end
    end

    assign path.filt = acc_r[spcf_pkg::ACC_W-1:spcf_pkg::ACC_FRAC];
endmodule : spcf_filter

/* File: hw/spcf_top.sv */
`timescale 1ns/1ps
module spcf_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic word_wr_in,
    input wire logic word_rd_in,
    input wire logic [5:0] word_addr_in,
    input wire logic [23:0] word_wdata_in,
    output logic [23:0] word_rdata_out,
    output logic word_rvalid_out,
    input wire logic supply_tracking_disable_in,
    input wire logic signed [11:0] sample_in,
    input wire logic sample_valid_in,
    output logic signed [11:0] curve_in_out,
    output logic curve_in_valid_out,
    output logic curve_enable_out,
    input wire logic signed [11:0] curve_result_in,
    input wire logic curve_result_valid_in,
    output logic [11:0] level_out,
    output logic level_valid_out,
    output logic [11:0] clamp_high_out,
    output logic [11:0] clamp_low_out,
    output logic [8:0] customer_tag_out
);
    logic [23:0] filter_trim_r;
    logic [23:0] curve_tag_r;
    logic [23:0] limits_r;
    logic curve_ok;
    logic pre_flip;
    logic post_flip;
    logic [5:0] hi_code;
    logic [5:0] lo_code;
    logic [11:0] hi_nxt;
    logic [11:0] lo_nxt;
    logic signed [11:0] post_src;
    logic post_src_valid;
    logic signed [11:0] post_r;
    logic post_valid_r;
    logic [11:0] ubias;

    spcf_path_if path ();

    function automatic logic signed [11:0] neg_sat(
        input logic signed [11:0] v);
        if (v == spcf_pkg::SMIN)
            neg_sat = spcf_pkg::SMAX;
        else
            neg_sat = -v;
    endfunction : neg_sat

    // Configuration words
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            filter_trim_r <= spcf_pkg::WORD_RESET;
            curve_tag_r <= spcf_pkg::WORD_RESET;
            limits_r <= spcf_pkg::WORD_RESET;
        end
        else if (word_wr_in)
        begin
            case (word_addr_in)
                spcf_pkg::FILTER_TRIM_OFS: filter_trim_r <= word_wdata_in;
                spcf_pkg::CURVE_TAG_OFS: curve_tag_r <= word_wdata_in;
                spcf_pkg::LIMITS_OFS: limits_r <= word_wdata_in;
                default: ;
            endcase
        end
    end

    // Word readback
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            word_rdata_out <= '0;
            word_rvalid_out <= 1'b0;
        end
        else
        begin
            word_rvalid_out <= word_rd_in;
            if (word_rd_in)
            begin
                case (word_addr_in)
                    spcf_pkg::FILTER_TRIM_OFS: word_rdata_out <= filter_trim_r;
                    spcf_pkg::CURVE_TAG_OFS: word_rdata_out <= curve_tag_r;
                    spcf_pkg::LIMITS_OFS: word_rdata_out <= limits_r;
                    default: word_rdata_out <= '0;
                endcase
            end
        end
    end

    assign curve_ok = curve_tag_r[spcf_pkg::CURVE_VALID_BIT];
    assign pre_flip = curve_ok && curve_tag_r[spcf_pkg::PRE_FLIP_BIT];
    assign post_flip = curve_ok && curve_tag_r[spcf_pkg::POST_FLIP_BIT];

    // Bandwidth filter
    assign path.raw = sample_in;
    assign path.raw_valid = sample_valid_in;
    assign path.bw_sel = filter_trim_r[spcf_pkg::BW_LSB +: 2];

    spcf_filter u_filter (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .path(path)
    );

    // Stage before the curve
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            curve_in_out <= '0;
            curve_in_valid_out <= 1'b0;
            curve_enable_out <= 1'b0;
        end
        else
        begin
            curve_in_valid_out <= path.filt_valid;
            curve_enable_out <= curve_ok;
            if (path.filt_valid)
                curve_in_out <= pre_flip ? neg_sat(path.filt)
                    : path.filt;
        end
    end

    // Curve result only when the table is valid
    always_comb
    begin
        if (curve_ok)
        begin
            post_src = curve_result_in;
            post_src_valid = curve_result_valid_in;
        end
        else
        begin
            post_src = curve_in_out;
            post_src_valid = curve_in_valid_out;
        end
    end

    // Stage after the curve
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            post_r <= '0;
            post_valid_r <= 1'b0;
        end
        else
        begin
            post_valid_r <= post_src_valid;
            if (post_src_valid)
                post_r <= post_flip ? neg_sat(post_src) : post_src;
        end
    end

    // Clamp levels
    assign hi_code = limits_r[spcf_pkg::CLAMP_HI_LSB +: spcf_pkg::CLAMP_W];
    assign lo_code = limits_r[spcf_pkg::CLAMP_LO_LSB +: spcf_pkg::CLAMP_W];
    assign hi_nxt = spcf_pkg::FULL_SCALE
        - 12'(hi_code * spcf_pkg::CLAMP_STEP_LSB);
    assign lo_nxt = 12'(lo_code * spcf_pkg::CLAMP_STEP_LSB);

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            clamp_high_out <= spcf_pkg::FULL_SCALE;
            clamp_low_out <= '0;
            customer_tag_out <= '0;
        end
        else
        begin
            clamp_high_out <= hi_nxt;
            clamp_low_out <= lo_nxt;
            customer_tag_out <= curve_tag_r[spcf_pkg::TAG_MSB:spcf_pkg::TAG_LSB];
        end
    end

    // Clamped output level
    assign ubias = post_r + spcf_pkg::MID_OFFSET;

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            level_out <= spcf_pkg::MID_OFFSET;
            level_valid_out <= 1'b0;
        end
        else
        begin
            level_valid_out <= post_valid_r;
            if (post_valid_r)
            begin
                if (ubias > hi_nxt)
                    level_out <= hi_nxt;
                else if (ubias < lo_nxt)
                    level_out <= lo_nxt;
                else
                    level_out <= ubias;
            end
        end
    end

    logic unused_tracking;
    assign unused_tracking = supply_tracking_disable_in;
endmodule : spcf_top

/* File: sim/spcf_chk_assertions.sv */
`timescale 1ns/1ps
module spcf_chk (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic word_wr_in,
    input wire logic [5:0] word_addr_in,
    input wire logic [23:0] word_wdata_in,
    input wire logic sample_valid_in,
    input wire logic curve_in_valid_out,
    input wire logic curve_enable_out,
    input wire logic curve_result_valid_in,
    input wire logic [11:0] level_out,
    input wire logic level_valid_out,
    input wire logic [11:0] clamp_high_out,
    input wire logic [11:0] clamp_low_out,
    input wire logic [8:0] customer_tag_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_clamp_hi_code: assert property (
        word_wr_in && word_addr_in == 6'h1C |-> ##2 clamp_high_out ==
        12'hFFF - {1'b0, $past(word_wdata_in[23:18], 2), 5'h00})
        else $error("upper clamp wrong");
    a_clamp_lo_code: assert property (
        word_wr_in && word_addr_in == 6'h1C |-> ##2
        clamp_low_out == {1'b0, $past(word_wdata_in[17:12], 2), 5'h00})
        else $error("lower clamp wrong");
    a_tag_kept: assert property (
        word_wr_in && word_addr_in == 6'h1B |-> ##2
        customer_tag_out == $past(word_wdata_in[20:12], 2))
        else $error("tag wrong");
    a_curve_flag_map: assert property (
        word_wr_in && word_addr_in == 6'h1B |-> ##2
        curve_enable_out == $past(word_wdata_in[23], 2))
        else $error("curve flag wrong");
    a_path_latency: assert property (
        sample_valid_in |-> ##2 curve_in_valid_out)
        else $error("filter latency wrong");
    a_bypass_latency: assert property (
        !curve_enable_out && curve_in_valid_out |-> ##2 level_valid_out)
        else $error("bypass latency wrong");
    a_curve_latency: assert property (
        curve_enable_out && curve_result_valid_in |-> ##2 level_valid_out)
        else $error("curve latency wrong");
    a_level_top: assert property (
        level_valid_out |-> level_out <= clamp_high_out)
        else $error("level above clamp");
    a_level_bottom: assert property (
        level_valid_out && clamp_low_out <= clamp_high_out
        |-> level_out >= clamp_low_out)
        else $error("level below clamp");
endmodule : spcf_chk

bind spcf_top spcf_chk u_chk (.*);

/* File: sim/spcf_curve_model.sv */
`timescale 1ns/1ps
module spcf_curve_model (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic signed [11:0] curve_in_out,
    input wire logic curve_in_valid_out,
    output logic signed [11:0] curve_result_in,
    output logic curve_result_valid_in
);
    // Halving curve one cycle late; data churns between results
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            curve_result_in <= 12'sh000;
            curve_result_valid_in <= 1'b0;
        end
        else
        begin
            curve_result_valid_in <= curve_in_valid_out;
            curve_result_in <= curve_in_valid_out ?
                curve_in_out >>> 1 : ~curve_result_in;
        end
    end
endmodule : spcf_curve_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic mclk_in = 1'b0, rst_in = 1'b1, word_wr_in = 1'b0;
    logic word_rd_in = 1'b0, sample_valid_in = 1'b0;
    logic supply_tracking_disable_in = 1'b1;
    logic [5:0] word_addr_in = 6'h00;
    logic [23:0] word_wdata_in = 24'h000000, word_rdata_out;
    logic signed [11:0] sample_in = 12'sh000;
    logic signed [11:0] curve_in_out, curve_result_in;
    logic word_rvalid_out, curve_in_valid_out, curve_enable_out;
    logic curve_result_valid_in, level_valid_out;
    logic [11:0] level_out, clamp_high_out, clamp_low_out;
    logic [8:0] customer_tag_out;
    int n_fail = 0, total_checks = 0;
    typedef struct {logic [1:0] bw; logic [23:0] c, l; logic [11:0] x;
        int n; logic [11:0] ci, lv;} spcf_row_s;
    spcf_row_s rows[9] = '{
        '{2'b00, 24'hA00000, 24'h0, 12'h400, 1, 12'hFC0, 12'h7E0},
        '{2'b00, 24'hE00000, 24'h0, 12'h400, 1, 12'hFC0, 12'h820},
        '{2'b00, 24'h600000, 24'h0, 12'h400, 1, 12'h040, 12'h840},
        '{2'b01, 24'h0, 24'h0, 12'h400, 1, 12'h040, 12'h840},
        '{2'b10, 24'h0, 24'h0, 12'h400, 1, 12'h010, 12'h810},
        '{2'b11, 24'h0, 24'h0, 12'h400, 1, 12'h080, 12'h880},
        '{2'b11, 24'hA00000, 24'h0, 12'h800, 300, 12'h7FF, 12'hBFF},
        '{2'b00, 24'h0, 24'hFFF000, 12'h400, 1, 12'h040, 12'h81F},
        '{2'b00, 24'h0, 24'hFFF000, 12'hC00, 1, 12'hFC0, 12'h7E0}};
    always #2 mclk_in = ~mclk_in;
    spcf_top DUT (.*);
    spcf_curve_model u_curve (.*);
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : cyc
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        cyc(1);
        word_wr_in = 1'b1;
        word_addr_in = a;
        word_wdata_in = d;
        cyc(1);
        word_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        cyc(1);
        word_rd_in = 1'b1;
        word_addr_in = a;
        cyc(1);
        word_rd_in = 1'b0;
        chk({23'h0, word_rvalid_out}, 24'h1);
        chk(word_rdata_out, exp);
    endtask : rd
    task automatic t_reset_vals;
        rd(6'h08, 24'h0);
        rd(6'h1B, 24'h0);
        rd(6'h1C, 24'h0);
        chk({12'h0, clamp_high_out}, 24'hFFF);
        chk({12'h0, clamp_low_out}, 24'h0);
        chk({12'h0, level_out}, 24'h800);
        $display("t_reset_vals done");
    endtask : t_reset_vals
    task automatic t_regs;
        wr(6'h08, 24'hFFFFFF);
        wr(6'h1B, 24'h1AB123);
        wr(6'h09, 24'hFFFFFF);
        wr(6'h1C, 24'hFFFFFF);
        rd(6'h08, 24'hFFFFFF);
        rd(6'h1B, 24'h1AB123);
        rd(6'h09, 24'h0);
        chk({15'h0, customer_tag_out}, 24'h1AB);
        chk({clamp_high_out, clamp_low_out}, 24'h81F7E0);
        wr(6'h1C, 24'h042000);
        cyc(2);
        chk({clamp_high_out, clamp_low_out}, 24'hFDF040);
        supply_tracking_disable_in = 1'b0;
        cyc(2);
        chk({clamp_high_out, clamp_low_out}, 24'hFDF040);
        supply_tracking_disable_in = 1'b1;
        $display("t_regs done");
    endtask : t_regs
    task automatic t_path;
        foreach (rows[i])
        begin
            rst_in = 1'b1;
            cyc(6);
            rst_in = 1'b0;
            wr(6'h08, {22'h0, rows[i].bw});
            wr(6'h1B, rows[i].c);
            wr(6'h1C, rows[i].l);
            cyc(2);
            sample_in = rows[i].x;
            sample_valid_in = 1'b1;
            cyc(rows[i].n);
            sample_valid_in = 1'b0;
            cyc(8);
            chk({12'h0, curve_in_out}, rows[i].ci);
            chk({12'h0, level_out}, rows[i].lv);
        end
        $display("t_path done");
    endtask : t_path
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial
    begin
        cyc(6);
        rst_in = 1'b0;
        t_reset_vals;
        t_regs;
        t_path;
        give_verdict;
    end
endmodule : testbench
